// [core/flash_pm_map.svh]
// Opcodes, field values and timing figures of the power-mode and page-size logic
`ifndef FLASH_PM_MAP_SVH
`define FLASH_PM_MAP_SVH

// Opcodes
`define OP_DEEP_ENTER 8'hB9
`define OP_DEEP_RESUME 8'hAB
`define OP_ULTRA_ENTER 8'h79
`define OP_CFG_B0 8'h3D
`define OP_CFG_B1 8'h2A
`define OP_CFG_B2 8'h80
`define OP_CFG_BIN 8'hA6
`define OP_CFG_STD 8'hA7

// Frame layout
`define CFG_LEN 3'h4
`define CMD_BYTES 4
`define BIT_ALIGNED 3'h0
`define BYTE_CNT_MAX 3'h7

// Page-size flag encoding
`define PAGE_SIZE_STD 1'b0
`define PAGE_SIZE_BIN 1'b1

// Timing, in ns
`define CLK_PERIOD_NS 20
`define DEEP_ENTRY_TIME_NS 3000
`define DEEP_RESUME_TIME_NS 8000
`define ULTRA_ENTRY_TIME_NS 3000
`define ULTRA_EXIT_LOW_PULSE_NS 20
`define ULTRA_EXIT_TIME_NS 100000
`define CONFIG_PROGRAM_TIME_NS 4000000

`endif

// [core/flash_pm_pkg.sv]
// Types shared by the power-mode and page-size logic
package flash_pm_pkg;

  // Gray codes along standby -> deep -> resume and standby -> ultra -> exit
  typedef enum logic [2:0] {
    ST_STANDBY     = 3'h0,
    ST_ENTER_DEEP  = 3'h1,
    ST_DEEP        = 3'h3,
    ST_RESUMING    = 3'h2,
    ST_ENTER_ULTRA = 3'h4,
    ST_ULTRA       = 3'h5,
    ST_ULTRA_EXIT  = 3'h7
  } power_state_e;

endpackage

// [core/spi_frame_shifter.sv]
// Serial pin synchroniser, bit shifter and frame counters
`include "flash_pm_map.svh"

module spi_frame_shifter (
  input wire logic clk_i,
  input wire logic resetn_i,
  input wire logic cs_n_pin_i,
  input wire logic sck_pin_i,
  input wire logic si_pin_i,
  output logic cs_low_o,
  output logic cs_fall_o,
  output logic cs_rise_o,
  output logic byte_valid_o,
  output logic [7:0] byte_o,
  output logic [2:0] byte_idx_o,
  output logic [2:0] byte_cnt_o,
  output logic aligned_o
);

  logic [1:0] cs_sync;
  logic [1:0] sck_sync;
  logic [1:0] si_sync;
  logic cs_q;
  logic sck_q;
  logic cs_rise_d;
  logic [2:0] bit_cnt;
  logic [6:0] shift;

  wire cs_low = ~cs_sync[1];
  wire sck_rise = sck_sync[1] & ~sck_q & cs_low;
  wire byte_done = sck_rise & (bit_cnt == 3'h7);
  wire cs_fall_now = cs_low & cs_q;
  wire cs_rise_now = ~cs_low & ~cs_q;

  assign cs_low_o = cs_low;
  assign aligned_o = (bit_cnt == `BIT_ALIGNED);

  ////////////////////////////////////////////////////////////////////////////
  // Pins cross in through two flops each
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      cs_sync <= 2'h3;
      sck_sync <= 2'h0;
      si_sync <= 2'h0;
      cs_q <= 1'b1;
      sck_q <= 1'b0;
    end else begin
      cs_sync <= {cs_sync[0], cs_n_pin_i};
      sck_sync <= {sck_sync[0], sck_pin_i};
      si_sync <= {si_sync[0], si_pin_i};
      cs_q <= cs_sync[1];
      sck_q <= sck_sync[1];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Frame end is delayed two cycles so a last clock edge next to it lands first
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      cs_fall_o <= 1'b0;
      cs_rise_d <= 1'b0;
      cs_rise_o <= 1'b0;
    end else begin
      cs_fall_o <= cs_fall_now;
      cs_rise_d <= cs_rise_now;
      cs_rise_o <= cs_rise_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Bit and byte counting, MSB first
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      bit_cnt <= 3'h0;
      shift <= 7'h00;
      byte_cnt_o <= 3'h0;
      byte_idx_o <= 3'h0;
      byte_o <= 8'h00;
      byte_valid_o <= 1'b0;
    end else begin
      byte_valid_o <= byte_done;
      if (cs_fall_now) begin
        bit_cnt <= 3'h0;
        byte_cnt_o <= 3'h0;
      end else if (sck_rise) begin
        bit_cnt <= bit_cnt + 3'h1;
        shift <= {shift[5:0], si_sync[1]};
        if (byte_done) begin
          byte_o <= {shift, si_sync[1]};
          byte_idx_o <= byte_cnt_o;
          if (byte_cnt_o != `BYTE_CNT_MAX) begin
            byte_cnt_o <= byte_cnt_o + 3'h1;
          end
        end
      end
    end
  end

endmodule

// [core/flash_power_mode_page_config.sv]
// Power-mode, suspend-flag and page-size command logic of a serial flash
// Function
// - While buffer-1 program is suspended, commands that modify buffer 1 are ignored.
// - Erase-suspend flag is set when any erase is suspended.
// - Device sits in standby while deselected and idle.
// - Deep mode ignores every command except resume.
// - Opcode B9h then deselect enters deep mode within its entry time.
// - Incomplete or misaligned deep entry aborts; device stays in standby.
// - Deep entry is ignored while a program or erase runs.
// - Opcode ABh then deselect returns to standby within the resume time.
// - Incomplete or misaligned resume aborts; device stays in deep mode.
// - Opcode 79h then deselect enters ultra mode within its entry time.
// - Ultra mode ignores all commands, resume included.
// - Entering ultra mode discards both data buffers.
// - Incomplete or misaligned ultra entry aborts; device stays in standby.
// - Ultra entry is ignored while a program or erase runs.
// - A long enough select pulse leaves ultra mode within the exit time.
// - A command begun before the exit time ends is ignored.
// - Power-up always lands in standby.
// - Sequence 3Dh 2Ah 80h A6h selects the 256-byte page size.
// - Same prefix ending A7h selects the 264-byte page size.
// - Deselect after a size sequence runs a timed program, reported busy.
// - New page size applies when that program completes.
// - Page size lives in nonvolatile storage and can change both ways.
// - Ready flag is 0 while an internal operation runs, 1 when ready.
// - Page-size flag is 0 for 264 bytes and 1 for 256 bytes.
`include "flash_pm_map.svh"

module flash_power_mode_page_config
  import flash_pm_pkg::*;
#(
  parameter int TIMER_W = 20,
  parameter int DEEP_ENTRY_CYCLES = `DEEP_ENTRY_TIME_NS / `CLK_PERIOD_NS,
  parameter int DEEP_RESUME_CYCLES = `DEEP_RESUME_TIME_NS / `CLK_PERIOD_NS,
  parameter int ULTRA_ENTRY_CYCLES = `ULTRA_ENTRY_TIME_NS / `CLK_PERIOD_NS,
  parameter int ULTRA_LOW_CYCLES =
    (`ULTRA_EXIT_LOW_PULSE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS,
  parameter int ULTRA_EXIT_CYCLES = `ULTRA_EXIT_TIME_NS / `CLK_PERIOD_NS,
  parameter int CONFIG_PROGRAM_CYCLES = `CONFIG_PROGRAM_TIME_NS / `CLK_PERIOD_NS
) (
  input wire logic clk_i,
  input wire logic resetn_i,
  input wire logic cs_n_i,
  input wire logic sck_i,
  input wire logic si_i,
  input wire logic array_busy_i,
  input wire logic buf1_suspend_set_i,
  input wire logic buf1_suspend_clr_i,
  input wire logic erase_suspend_set_i,
  input wire logic erase_suspend_clr_i,
  input wire logic buf1_modify_req_i,
  input wire logic nv_page_size_i,
  output logic buf1_modify_grant_o,
  output logic buf1_prog_suspended_o,
  output logic erase_suspended_flag_o,
  output logic status_ready_o,
  output logic page_size_binary_o,
  output logic standby_o,
  output logic deep_mode_o,
  output logic ultra_mode_o,
  output logic cmd_enable_o,
  output logic buffer_discard_o,
  output logic nv_prog_o,
  output logic nv_prog_data_o
);

  ////////////////////////////////////////////////////////////////////////////
  // Elaboration checks
  localparam logic [TIMER_W-1:0] DEEP_ENTRY_LD = TIMER_W'(DEEP_ENTRY_CYCLES - 1);
  localparam logic [TIMER_W-1:0] DEEP_RESUME_LD = TIMER_W'(DEEP_RESUME_CYCLES - 1);
  localparam logic [TIMER_W-1:0] ULTRA_ENTRY_LD = TIMER_W'(ULTRA_ENTRY_CYCLES - 1);
  localparam logic [TIMER_W-1:0] ULTRA_LOW_MIN = TIMER_W'(ULTRA_LOW_CYCLES);
  localparam logic [TIMER_W-1:0] ULTRA_EXIT_LD = TIMER_W'(ULTRA_EXIT_CYCLES - 1);
  localparam logic [TIMER_W-1:0] CFG_PROG_LD = TIMER_W'(CONFIG_PROGRAM_CYCLES - 1);
  localparam longint TIMER_LIMIT = longint'(1) << TIMER_W;

  if (DEEP_ENTRY_CYCLES < 1 || DEEP_RESUME_CYCLES < 1 || ULTRA_ENTRY_CYCLES < 1 ||
      ULTRA_LOW_CYCLES < 1 || ULTRA_EXIT_CYCLES < 1 || CONFIG_PROGRAM_CYCLES < 1) begin : g_min
    $error("Every timing count must be at least one cycle");
  end
  if (TIMER_W < 4 || TIMER_W > 31 || CONFIG_PROGRAM_CYCLES >= TIMER_LIMIT ||
      ULTRA_EXIT_CYCLES >= TIMER_LIMIT || DEEP_RESUME_CYCLES >= TIMER_LIMIT ||
      DEEP_ENTRY_CYCLES >= TIMER_LIMIT || ULTRA_ENTRY_CYCLES >= TIMER_LIMIT) begin : g_fit
    $error("Timing counts do not fit the timer width");
  end

  ////////////////////////////////////////////////////////////////////////////
  // Serial front end
  logic cs_low;
  logic cs_fall;
  logic cs_rise;
  logic byte_valid;
  logic [7:0] rx_byte;
  logic [2:0] byte_idx;
  logic [2:0] byte_cnt;
  logic aligned;

  spi_frame_shifter u_shifter (
    .clk_i(clk_i),
    .resetn_i(resetn_i),
    .cs_n_pin_i(cs_n_i),
    .sck_pin_i(sck_i),
    .si_pin_i(si_i),
    .cs_low_o(cs_low),
    .cs_fall_o(cs_fall),
    .cs_rise_o(cs_rise),
    .byte_valid_o(byte_valid),
    .byte_o(rx_byte),
    .byte_idx_o(byte_idx),
    .byte_cnt_o(byte_cnt),
    .aligned_o(aligned)
  );

  ////////////////////////////////////////////////////////////////////////////
  // State
  power_state_e state;
  power_state_e next_state;
  logic [TIMER_W-1:0] pm_timer;
  logic [TIMER_W-1:0] next_pm_timer;
  logic [TIMER_W-1:0] cfg_timer;
  logic [7:0] cmd_byte [`CMD_BYTES];
  logic frame_void;
  logic cfg_busy;
  logic cfg_target;
  logic page_size;
  logic nv_loaded;
  logic buf1_susp;
  logic erase_susp;

  ////////////////////////////////////////////////////////////////////////////
  // Command decode at deselect
  wire ready = ~(array_busy_i | cfg_busy);
  // Only whole bytes count; frames begun in a transient state never count
  wire frame_ok = cs_rise & ~frame_void & aligned & (byte_cnt != 3'h0);
  wire in_standby = (state == ST_STANDBY);
  wire is_deep_enter = (cmd_byte[0] == `OP_DEEP_ENTER);
  wire is_ultra_enter = (cmd_byte[0] == `OP_ULTRA_ENTER);
  wire is_resume = (cmd_byte[0] == `OP_DEEP_RESUME);
  wire cfg_prefix = (cmd_byte[0] == `OP_CFG_B0) & (cmd_byte[1] == `OP_CFG_B1) &
                    (cmd_byte[2] == `OP_CFG_B2) & (byte_cnt >= `CFG_LEN);
  wire cfg_bin = cfg_prefix & (cmd_byte[3] == `OP_CFG_BIN);
  wire cfg_std = cfg_prefix & (cmd_byte[3] == `OP_CFG_STD);
  wire commit_deep = in_standby & frame_ok & is_deep_enter & ready;
  wire commit_ultra = in_standby & frame_ok & is_ultra_enter & ready;
  wire commit_cfg = in_standby & frame_ok & (cfg_bin | cfg_std) & ready;
  wire commit_resume = (state == ST_DEEP) & frame_ok & is_resume;
  wire timer_zero = (pm_timer == '0);
  wire cfg_done = cfg_busy & (cfg_timer == '0);

  ////////////////////////////////////////////////////////////////////////////
  // Power-mode sequencing
  always_comb begin
    next_state = state;
    next_pm_timer = pm_timer;
    case (state)
      ST_STANDBY: begin
        if (commit_deep) begin
          next_state = ST_ENTER_DEEP;
          next_pm_timer = DEEP_ENTRY_LD;
        end else if (commit_ultra) begin
          next_state = ST_ENTER_ULTRA;
          next_pm_timer = ULTRA_ENTRY_LD;
        end
      end
      ST_ENTER_DEEP: begin
        if (timer_zero) begin
          next_state = ST_DEEP;
        end else begin
          next_pm_timer = pm_timer - 1'b1;
        end
      end
      ST_DEEP: begin
        if (commit_resume) begin
          next_state = ST_RESUMING;
          next_pm_timer = DEEP_RESUME_LD;
        end
      end
      ST_RESUMING: begin
        if (timer_zero) begin
          next_state = ST_STANDBY;
        end else begin
          next_pm_timer = pm_timer - 1'b1;
        end
      end
      ST_ENTER_ULTRA: begin
        if (timer_zero) begin
          next_state = ST_ULTRA;
        end else begin
          next_pm_timer = pm_timer - 1'b1;
        end
      end
      ST_ULTRA: begin
        // Timer measures the select pulse; clocked bits are ignored
        if (cs_rise) begin
          if (pm_timer >= ULTRA_LOW_MIN) begin
            next_state = ST_ULTRA_EXIT;
            next_pm_timer = ULTRA_EXIT_LD;
          end else begin
            next_pm_timer = '0;
          end
        end else if (cs_low && pm_timer < ULTRA_LOW_MIN) begin
          next_pm_timer = pm_timer + 1'b1;
        end
      end
      ST_ULTRA_EXIT: begin
        if (timer_zero) begin
          next_state = ST_STANDBY;
        end else begin
          next_pm_timer = pm_timer - 1'b1;
        end
      end
      default: begin
        next_state = ST_STANDBY;
        next_pm_timer = '0;
      end
    endcase
  end

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      state <= ST_STANDBY;
      pm_timer <= '0;
    end else begin
      state <= next_state;
      pm_timer <= next_pm_timer;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Frame qualification and opcode capture
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      frame_void <= 1'b0;
    end else if (cs_fall) begin
      // Ultra and transient states swallow the whole frame
      frame_void <= ~(in_standby | (state == ST_DEEP));
    end
  end

  for (genvar i = 0; i < `CMD_BYTES; i++) begin : g_cmd
    always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
        cmd_byte[i] <= 8'h00;
      end else if (cs_fall) begin
        cmd_byte[i] <= 8'h00;
      end else if (byte_valid && byte_idx == 3'(i)) begin
        cmd_byte[i] <= rx_byte;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Page-size configuration and its nonvolatile program cycle
  // The stored size is caught once after reset; a strap must not load async
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      nv_loaded <= 1'b0;
      page_size <= `PAGE_SIZE_STD;
      cfg_busy <= 1'b0;
      cfg_target <= `PAGE_SIZE_STD;
      cfg_timer <= '0;
    end else begin
      if (!nv_loaded) begin
        nv_loaded <= 1'b1;
        page_size <= nv_page_size_i;
      end else if (cfg_done) begin
        page_size <= cfg_target;
      end
      if (commit_cfg) begin
        cfg_busy <= 1'b1;
        cfg_target <= cfg_bin ? `PAGE_SIZE_BIN : `PAGE_SIZE_STD;
        cfg_timer <= CFG_PROG_LD;
      end else if (cfg_done) begin
        cfg_busy <= 1'b0;
      end else if (cfg_busy) begin
        cfg_timer <= cfg_timer - 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Suspend flags; a set in the clearing cycle wins
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      buf1_susp <= 1'b0;
      erase_susp <= 1'b0;
    end else begin
      buf1_susp <= buf1_suspend_set_i | (buf1_susp & ~buf1_suspend_clr_i);
      erase_susp <= erase_suspend_set_i | (erase_susp & ~erase_suspend_clr_i);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      buffer_discard_o <= 1'b0;
    end else begin
      buffer_discard_o <= commit_ultra;
    end
  end

  assign buf1_prog_suspended_o = buf1_susp;
  assign erase_suspended_flag_o = erase_susp;
  assign buf1_modify_grant_o = buf1_modify_req_i & ~buf1_susp & in_standby;
  assign status_ready_o = ready;
  assign page_size_binary_o = page_size;
  assign standby_o = in_standby & ~cs_low & ready;
  assign deep_mode_o = (state == ST_DEEP);
  assign ultra_mode_o = (state == ST_ULTRA);
  // Other command decoders only run in standby, never in a low-power mode
  assign cmd_enable_o = in_standby & ~frame_void;
  assign nv_prog_o = cfg_busy;
  assign nv_prog_data_o = cfg_target;

endmodule

// [tb/flash_pm_checker_assertions.sv]
// Concurrent checks on the power-mode, suspend-flag and page-size logic
module flash_pm_checker #(
  parameter int ULTRA_ENTRY_CYCLES = 150
) (
  input wire logic clk_i,
  input wire logic resetn_i,
  input wire logic array_busy_i,
  input wire logic buf1_suspend_set_i,
  input wire logic erase_suspend_set_i,
  input wire logic buf1_modify_grant_o,
  input wire logic buf1_prog_suspended_o,
  input wire logic erase_suspended_flag_o,
  input wire logic status_ready_o,
  input wire logic page_size_binary_o,
  input wire logic standby_o,
  input wire logic deep_mode_o,
  input wire logic ultra_mode_o,
  input wire logic cmd_enable_o,
  input wire logic buffer_discard_o,
  input wire logic nv_prog_o,
  input wire logic nv_prog_data_o
);
  // Slack of two cycles covers the commit edge after the discard pulse
  localparam int ULTRA_WAIT = ULTRA_ENTRY_CYCLES + 2;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!resetn_i);
  ////////////////////////////////////////////////////////////////////////////////
  sequence prog_start_s;
    $rose(nv_prog_o);
  endsequence
  sequence prog_hold_s;
    nv_prog_o[*8];
  endsequence
  sequence discard_s;
    buffer_discard_o ##1 !buffer_discard_o;
  endsequence
  ////////////////////////////////////////////////////////////////////////////////
  chk_grant_when_susp: assert property (buf1_prog_suspended_o |-> !buf1_modify_grant_o)
    else $error("buffer 1 modify granted while suspended");
  chk_buf1_flag_set: assert property (buf1_suspend_set_i |=> buf1_prog_suspended_o)
    else $error("buffer 1 suspend flag not set");
  chk_erase_flag_set: assert property (erase_suspend_set_i |=> erase_suspended_flag_o)
    else $error("erase suspend flag not set");
  chk_busy_not_ready: assert property ((array_busy_i || nv_prog_o) |-> !status_ready_o)
    else $error("ready reported during internal operation");
  chk_lowpower_no_cmd: assert property ((deep_mode_o || ultra_mode_o) |-> !cmd_enable_o)
    else $error("command enabled in low-power mode");
  chk_ultra_persists: assert property (ultra_mode_o |=> !deep_mode_o && !standby_o)
    else $error("ultra mode left straight for deep mode or standby");
  chk_busy_no_entry: assert property (array_busy_i[*8] |-> !$rose(deep_mode_o)
    && !buffer_discard_o)
    else $error("low-power entry accepted while busy");
  chk_discard_ultra: assert property (discard_s |-> ##[0:ULTRA_WAIT] ultra_mode_o)
    else $error("ultra mode not reached after discard");
  chk_prog_length: assert property (prog_start_s |-> prog_hold_s)
    else $error("config program shorter than its time");
  chk_size_applied: assert property ($fell(nv_prog_o) |-> ##[0:1]
    page_size_binary_o == nv_prog_data_o)
    else $error("page size not applied after program");
  cov_ultra: cover property (discard_s);
endmodule

bind flash_power_mode_page_config flash_pm_checker #(
  .ULTRA_ENTRY_CYCLES(ULTRA_ENTRY_CYCLES)
) chk_u (
  .clk_i(clk_i), .resetn_i(resetn_i), .array_busy_i(array_busy_i),
  .buf1_suspend_set_i(buf1_suspend_set_i), .erase_suspend_set_i(erase_suspend_set_i),
  .buf1_modify_grant_o(buf1_modify_grant_o), .buf1_prog_suspended_o(buf1_prog_suspended_o),
  .erase_suspended_flag_o(erase_suspended_flag_o), .status_ready_o(status_ready_o),
  .page_size_binary_o(page_size_binary_o), .standby_o(standby_o), .deep_mode_o(deep_mode_o),
  .ultra_mode_o(ultra_mode_o), .cmd_enable_o(cmd_enable_o),
  .buffer_discard_o(buffer_discard_o), .nv_prog_o(nv_prog_o), .nv_prog_data_o(nv_prog_data_o)
);

// [tb/spi_host_model.sv]
// Serial host model driving select, clock and data into the command logic
module spi_host_model (
  input wire logic clk_i,
  output logic cs_n_o,
  output logic sck_o,
  output logic si_o
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    cs_n_o = 1'b1;
    sck_o = 1'b0;
    si_o = 1'b0;
  end
  task automatic tick(input int n);
    repeat (n) @(negedge clk_i);
  endtask
  // MSB first, three clocks a half so the sampler sees every level
  // Few size switches are issued, far under the storage endurance
  task automatic frame(input logic [31:0] data, input int nbits, input int post);
    cs_n_o = 1'b0;
    tick(4);
    for (int i = 0; i < nbits; i++) begin
      si_o = data[31 - i];
      tick(3);
      sck_o = 1'b1;
      tick(3);
      sck_o = 1'b0;
    end
    tick(3);
    cs_n_o = 1'b1;
    // Released data line must not keep showing the last bit
    si_o = ~si_o;
    tick(post);
  endtask
endmodule

// [tb/flash_power_mode_page_config_tb.sv]
// Self-checking bench for the power-mode and page-size command logic
module flash_power_mode_page_config_tb;
  import flash_pm_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  typedef struct packed {
    logic [31:0] data;
    logic [5:0] nbits;
    logic deep;
    logic ultra;
    logic page;
  } row_s;
  logic clk_i, resetn_i, cs_n_i, sck_i, si_i, array_busy_i, nv_page_size_i;
  logic buf1_suspend_set_i, buf1_suspend_clr_i, erase_suspend_set_i, erase_suspend_clr_i;
  logic buf1_modify_req_i, buf1_modify_grant_o, buf1_prog_suspended_o, erase_suspended_flag_o;
  logic status_ready_o, page_size_binary_o, standby_o, deep_mode_o, ultra_mode_o;
  logic cmd_enable_o, buffer_discard_o, nv_prog_o, nv_prog_data_o;
  int num_errors = 0;
  int compares = 0;
  // Row order matters: each row starts from the mode the previous one left
  localparam row_s rows [10] = '{
    '{32'hB9000000, 6'd8, 1'b1, 1'b0, 1'b0}, '{32'h9F000000, 6'd8, 1'b1, 1'b0, 1'b0},
    '{32'hAB000000, 6'd7, 1'b1, 1'b0, 1'b0}, '{32'hAB550000, 6'd16, 1'b0, 1'b0, 1'b0},
    '{32'hB9000000, 6'd7, 1'b0, 1'b0, 1'b0}, '{32'h79000000, 6'd12, 1'b0, 1'b0, 1'b0},
    '{32'h79AA0000, 6'd16, 1'b0, 1'b1, 1'b0}, '{32'hB9000000, 6'd8, 1'b0, 1'b0, 1'b0},
    '{32'h3D2A80A6, 6'd32, 1'b0, 1'b0, 1'b1}, '{32'h3D2A80A7, 6'd32, 1'b0, 1'b0, 1'b0}};
  ////////////////////////////////////////////////////////////////////////////////
  flash_power_mode_page_config #(
    .DEEP_ENTRY_CYCLES(4), .DEEP_RESUME_CYCLES(4), .ULTRA_ENTRY_CYCLES(4),
    .ULTRA_EXIT_CYCLES(8), .CONFIG_PROGRAM_CYCLES(10)
  ) dut_u (
    .clk_i(clk_i), .resetn_i(resetn_i), .cs_n_i(cs_n_i), .sck_i(sck_i), .si_i(si_i),
    .array_busy_i(array_busy_i), .buf1_suspend_set_i(buf1_suspend_set_i),
    .buf1_suspend_clr_i(buf1_suspend_clr_i), .erase_suspend_set_i(erase_suspend_set_i),
    .erase_suspend_clr_i(erase_suspend_clr_i), .buf1_modify_req_i(buf1_modify_req_i),
    .nv_page_size_i(nv_page_size_i), .buf1_modify_grant_o(buf1_modify_grant_o),
    .buf1_prog_suspended_o(buf1_prog_suspended_o),
    .erase_suspended_flag_o(erase_suspended_flag_o), .status_ready_o(status_ready_o),
    .page_size_binary_o(page_size_binary_o), .standby_o(standby_o),
    .deep_mode_o(deep_mode_o), .ultra_mode_o(ultra_mode_o), .cmd_enable_o(cmd_enable_o),
    .buffer_discard_o(buffer_discard_o), .nv_prog_o(nv_prog_o),
    .nv_prog_data_o(nv_prog_data_o)
  );
  spi_host_model host_u (.clk_i(clk_i), .cs_n_o(cs_n_i), .sck_o(sck_i), .si_o(si_i));
  initial clk_i = 1'b0;
  always #10 clk_i = ~clk_i;
  ////////////////////////////////////////////////////////////////////////////////
  task automatic check(input string name, input logic seen, input logic exp);
    compares++;
    if (seen !== exp) begin
      num_errors++;
      $display("BAD %s expected %b seen %b", name, exp, seen);
    end
  endtask
  task automatic tally_and_finish();
    $display("compares %0d num_errors %0d", compares, num_errors);
    if (num_errors == 0 && compares > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  initial begin
    #400000;
    num_errors++;
    tally_and_finish();
  end
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    {resetn_i, array_busy_i, nv_page_size_i, buf1_modify_req_i} = 4'h0;
    {buf1_suspend_set_i, buf1_suspend_clr_i, erase_suspend_set_i, erase_suspend_clr_i} = 4'h0;
    repeat (10) @(negedge clk_i);
    resetn_i = 1'b1;
    host_u.tick(3);
    for (int r = 0; r < 10; r++) begin
      host_u.frame(rows[r].data, int'(rows[r].nbits), 30);
      check("deep", deep_mode_o, rows[r].deep);
      check("ultra", ultra_mode_o, rows[r].ultra);
      check("page", page_size_binary_o, rows[r].page);
    end
    // Suspend flags and the buffer 1 guard
    buf1_modify_req_i = 1'b1;
    host_u.tick(1);
    check("grant", buf1_modify_grant_o, 1'b1);
    {buf1_suspend_set_i, erase_suspend_set_i} = 2'h3;
    host_u.tick(1);
    {buf1_suspend_set_i, erase_suspend_set_i} = 2'h0;
    host_u.tick(2);
    check("buf1 flag", buf1_prog_suspended_o, 1'b1);
    check("grant", buf1_modify_grant_o, 1'b0);
    check("erase flag", erase_suspended_flag_o, 1'b1);
    {buf1_suspend_clr_i, erase_suspend_clr_i} = 2'h3;
    host_u.tick(2);
    {buf1_suspend_clr_i, erase_suspend_clr_i} = 2'h0;
    check("erase flag", erase_suspended_flag_o, 1'b0);
    check("buf1 flag", buf1_prog_suspended_o, 1'b0);
    // Set and clear in one cycle: the set wins
    {erase_suspend_set_i, erase_suspend_clr_i} = 2'h3;
    host_u.tick(1);
    {erase_suspend_set_i, erase_suspend_clr_i} = 2'h0;
    check("erase flag", erase_suspended_flag_o, 1'b1);
    // Entries refused while the array is busy
    array_busy_i = 1'b1;
    host_u.tick(1);
    check("ready", status_ready_o, 1'b0);
    host_u.frame(32'hB9000000, 8, 30);
    check("deep", deep_mode_o, 1'b0);
    host_u.frame(32'h79000000, 8, 30);
    check("ultra", ultra_mode_o, 1'b0);
    array_busy_i = 1'b0;
    host_u.tick(1);
    check("ready", status_ready_o, 1'b1);
    // Size switch reports busy and applies only at completion
    host_u.frame(32'h3D2A80A6, 32, 7);
    check("ready", status_ready_o, 1'b0);
    check("page", page_size_binary_o, 1'b0);
    host_u.tick(30);
    check("page", page_size_binary_o, 1'b1);
    check("ready", status_ready_o, 1'b1);
    // Command begun during the ultra exit time is dropped
    host_u.frame(32'h79000000, 8, 30);
    host_u.frame(32'h0, 0, 6);
    host_u.frame(32'hB9000000, 8, 30);
    check("deep", deep_mode_o, 1'b0);
    check("standby", standby_o, 1'b1);
    // Reset in deep mode lands in standby with the stored size
    host_u.frame(32'hB9000000, 8, 30);
    check("deep", deep_mode_o, 1'b1);
    nv_page_size_i = 1'b1;
    resetn_i = 1'b0;
    host_u.tick(10);
    resetn_i = 1'b1;
    host_u.tick(3);
    check("deep", deep_mode_o, 1'b0);
    check("standby", standby_o, 1'b1);
    check("page", page_size_binary_o, 1'b1);
    tally_and_finish();
  end
endmodule
